/* File: pkg/cpllc_pkg.sv */
// Constants shared by the core clock generator and its rate multiplier
package cpllc_pkg;
  // Register byte offsets on the APB
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_PERIOD = 12'h008;
  // Control register fields and reset value
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_SYSTEM_CLOCK_OUTPUT_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  // Status register fields
  localparam int ST_DONE_BIT = 0;
  localparam int ST_BADSTRAP_BIT = 1;
  localparam int ST_SEL_LSB = 4;
  localparam int ST_STRAP_LSB = 8;
  localparam int ST_DIV_LSB = 12;
  // Divider strap encodings and divider values
  localparam logic [2:0] STRAP_DIV1 = 3'h0;
  localparam logic [2:0] STRAP_DIV2 = 3'h1;
  localparam logic [2:0] STRAP_DIV4 = 3'h2;
  localparam logic [2:0] STRAP_DIV6 = 3'h3;
  localparam logic [2:0] STRAP_DIV8 = 3'h4;
  localparam logic [3:0] DIV_1 = 4'h1;
  localparam logic [3:0] DIV_2 = 4'h2;
  localparam logic [3:0] DIV_4 = 4'h4;
  localparam logic [3:0] DIV_6 = 4'h6;
  localparam logic [3:0] DIV_8 = 4'h8;
  // Clock output select encodings
  localparam logic [1:0] CLKSEL_OFF = 2'h0;
  localparam logic [1:0] CLKSEL_OSC = 2'h1;
  localparam logic [1:0] CLKSEL_256 = 2'h2;
  localparam logic [1:0] CLKSEL_512 = 2'h3;
  // Rate factors against the 64x reference
  localparam int CORE_MULT = 56;
  localparam int OUT256_TOGGLES = 8;
  localparam int OUT512_TOGGLES = 16;
  // Initialization wait in reference cycles (two to the fifteenth)
  localparam int INIT_REF_CYCLES = 32768;
  // Generator states, Gray along the path
  typedef enum logic [1:0] {
    ST_CAPTURE = 2'h0,
    ST_INIT = 2'h1,
    ST_RUN = 2'h3
  } cpllc_state_type;
endpackage

/* File: rtl/cpllc_rate_mult.sv */
// Fractional rate multiplier: FACTOR ticks per measured reference period
`timescale 1ns/1ns
`default_nettype none
module cpllc_rate_mult #(
  parameter int FACTOR = 56,
  parameter int PER_W = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Control
  input wire logic run,
  input wire logic [PER_W-1:0] period,
  // Output pulse
  output logic tick_r
);
  localparam logic [PER_W:0] STEP = (PER_W+1)'(FACTOR);
  logic [PER_W:0] acc_r; // Phase accumulator
  logic [PER_W:0] sum; // Accumulator plus step

  assign sum = acc_r + STEP;

  // Add the factor each cycle, wrap by the period and emit a tick
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      acc_r <= '0;
      tick_r <= 1'b0;
    end else if (!run || period == '0) begin
      // Held idle while blocked or before a period is known
      acc_r <= '0;
      tick_r <= 1'b0;
    end else if (sum >= {1'b0, period}) begin
      acc_r <= sum - {1'b0, period};
      tick_r <= 1'b1;
    end else begin
      acc_r <= sum;
      tick_r <= 1'b0;
    end
  end
endmodule // cpllc_rate_mult
`default_nettype wire

/* File: rtl/cpllc_core.sv */
// Core clock generator with strap sampling, init wait and clock output
// Limits
// The crystal is sampled, so it must run below half of core_clk.
// The reference period must be at least 56 core_clk cycles, or core
// pulses are lost.
// Core pulses model the multiplied clock as a rate; downstream logic
// uses them as enables, not as a clock.
// Release falls at an arbitrary crystal phase, so the first reference
// cycle of the init wait is partial.
// Invalid divider codes fall back to a divider of one and are flagged.
// Writes during the init wait are refused with an error response.
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module cpllc_core #(
  parameter int PER_W = 16,
  parameter int INIT_CYCLES = cpllc_pkg::INIT_REF_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Crystal input, sampled
  input wire logic xtal_in,
  // Straps
  input wire logic divider_strap_bit0,
  input wire logic divider_strap_bit1,
  input wire logic divider_strap_bit2,
  input wire logic clkoutput_sel_bit0,
  input wire logic clkoutput_sel_bit1,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Generated clocks and status
  output logic system_clock_output,
  output logic core_tick,
  output logic ref_tick,
  output logic subsys_clk_en,
  output logic init_done
);
  // Divider value from the strap code; unknown codes fall back to one
  function automatic logic [3:0] decode_div(input logic [2:0] code);
    logic [3:0] d;
    d = cpllc_pkg::DIV_1;
    if (code == cpllc_pkg::STRAP_DIV2) d = cpllc_pkg::DIV_2;
    else if (code == cpllc_pkg::STRAP_DIV4) d = cpllc_pkg::DIV_4;
    else if (code == cpllc_pkg::STRAP_DIV6) d = cpllc_pkg::DIV_6;
    else if (code == cpllc_pkg::STRAP_DIV8) d = cpllc_pkg::DIV_8;
    return d;
  endfunction

  localparam logic [15:0] INIT_LAST = 16'(INIT_CYCLES - 1);

  cpllc_pkg::cpllc_state_type state_r; // Generator state
  logic [2:0] strap_r; // Captured divider straps
  logic [1:0] sel_r; // Captured clock output select
  logic [3:0] div_r; // Active divider
  logic x_s1_r; // Synchroniser first stage
  logic x_s2_r; // Synchronised crystal level
  logic x_s3_r; // Previous level for edge detect
  logic x_rise; // Crystal rising edge
  logic [3:0] div_cnt_r; // Edges within one reference cycle
  logic ref_pulse_r; // One pulse per reference cycle
  logic [PER_W-1:0] meas_r; // Running period count
  logic [PER_W-1:0] period_r; // Last measured reference period
  logic [15:0] init_cnt_r; // Reference cycles counted through the init wait; frozen once it ends
  logic [1:0] ctrl_r; // Software control bits
  logic core_pulse; // Multiplier output, 56 per reference
  logic p256_pulse; // Toggle pulses for 256 fs output
  logic p512_pulse; // Toggle pulses for 512 fs output
  logic gen_run; // Multipliers allowed to run
  logic out_tgl_r; // Divided output clock level
  logic [31:0] rdata; // Read mux
  logic hit; // Address mapped

  assign gen_run = (state_r == cpllc_pkg::ST_RUN);
  assign x_rise = x_s2_r & ~x_s3_r;

  // Two-flop synchroniser and edge history for the crystal input
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      // Reset high: a rise needs a real low sample, so release makes no false edge
      x_s1_r <= 1'b1;
      x_s2_r <= 1'b1;
      x_s3_r <= 1'b1;
    end else begin
      x_s1_r <= xtal_in;
      x_s2_r <= x_s1_r;
      x_s3_r <= x_s2_r;
    end
  end

  // Sequencer: capture straps on release, then wait out the init period
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= cpllc_pkg::ST_CAPTURE;
      strap_r <= cpllc_pkg::STRAP_DIV1;
      sel_r <= cpllc_pkg::CLKSEL_OFF;
      div_r <= cpllc_pkg::DIV_1;
    end else begin
      case (state_r)
        cpllc_pkg::ST_CAPTURE: begin
          // Straps are caught once, so later pin changes have no effect
          strap_r <= {divider_strap_bit2, divider_strap_bit1, divider_strap_bit0};
          sel_r <= {clkoutput_sel_bit1, clkoutput_sel_bit0};
          div_r <= decode_div({divider_strap_bit2, divider_strap_bit1, divider_strap_bit0});
          state_r <= cpllc_pkg::ST_INIT;
        end
        cpllc_pkg::ST_INIT: begin
          // Leave once the last reference cycle of the wait is seen
          if (ref_pulse_r && init_cnt_r == INIT_LAST) begin
            state_r <= cpllc_pkg::ST_RUN;
          end
        end
        cpllc_pkg::ST_RUN: begin
          // Held until the next reset; straps are not looked at again
          state_r <= cpllc_pkg::ST_RUN;
        end
        default: begin
          state_r <= cpllc_pkg::ST_CAPTURE;
        end
      endcase
    end
  end

  // Divide crystal edges down to the 64 fs reference
  // Counter clears in the capture cycle, so the first reference needs D rises
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt_r <= '0;
      ref_pulse_r <= 1'b0;
    end else if (state_r == cpllc_pkg::ST_CAPTURE) begin
      div_cnt_r <= '0;
      ref_pulse_r <= 1'b0;
    end else if (x_rise) begin
      if (div_cnt_r == div_r - 4'h1) begin
        div_cnt_r <= '0;
        ref_pulse_r <= 1'b1;
      end else begin
        div_cnt_r <= div_cnt_r + 4'h1;
        ref_pulse_r <= 1'b0;
      end
    end else begin
      ref_pulse_r <= 1'b0;
    end
  end

  // Count reference cycles through the init wait
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      init_cnt_r <= '0;
    end else if (state_r == cpllc_pkg::ST_INIT && ref_pulse_r) begin
      init_cnt_r <= init_cnt_r + 16'h1;
    end
  end

  // Measure the reference period in core clocks; saturates if the crystal stops
  // The first capture after release is partial; it is replaced before init ends
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meas_r <= '0;
      period_r <= '0;
    end else if (ref_pulse_r) begin
      meas_r <= PER_W'(1);
      period_r <= meas_r;
    end else if (meas_r != '1) begin
      meas_r <= meas_r + PER_W'(1);
    end
  end

  // Core clock: 56 pulses per reference cycle
  // All three multipliers share one period so their pulse trains stay in step
  cpllc_rate_mult #(.FACTOR(cpllc_pkg::CORE_MULT), .PER_W(PER_W)) u_core_mult (
    .core_clk(core_clk),
    .nrst(nrst),
    .run(gen_run),
    .period(period_r),
    .tick_r(core_pulse)
  );

  // Toggle sources for the 256 fs and 512 fs outputs
  // Four output periods per reference give 256 fs, hence eight toggles
  cpllc_rate_mult #(.FACTOR(cpllc_pkg::OUT256_TOGGLES), .PER_W(PER_W)) u_out256 (
    .core_clk(core_clk),
    .nrst(nrst),
    .run(gen_run),
    .period(period_r),
    .tick_r(p256_pulse)
  );
  cpllc_rate_mult #(.FACTOR(cpllc_pkg::OUT512_TOGGLES), .PER_W(PER_W)) u_out512 (
    .core_clk(core_clk),
    .nrst(nrst),
    .run(gen_run),
    .period(period_r),
    .tick_r(p512_pulse)
  );

  // Divided output clock toggles on the selected source
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      out_tgl_r <= 1'b0;
    end else if (sel_r == cpllc_pkg::CLKSEL_256 && p256_pulse) begin
      out_tgl_r <= ~out_tgl_r;
    end else if (sel_r == cpllc_pkg::CLKSEL_512 && p512_pulse) begin
      out_tgl_r <= ~out_tgl_r;
    end
  end

  // Clock output pin mux; the oscillator copy runs even during init
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      system_clock_output <= 1'b0;
    end else if (!ctrl_r[cpllc_pkg::CTRL_SYSTEM_CLOCK_OUTPUT_BIT]) begin
      system_clock_output <= 1'b0;
    end else begin
      case (sel_r)
        cpllc_pkg::CLKSEL_OSC: system_clock_output <= x_s2_r;
        cpllc_pkg::CLKSEL_256: system_clock_output <= out_tgl_r;
        cpllc_pkg::CLKSEL_512: system_clock_output <= out_tgl_r;
        default: system_clock_output <= 1'b0;
      endcase
    end
  end

  // Subsystem clocks stay blocked until the init wait has ended
  // Enable and done come from one source, so they cannot disagree
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      core_tick <= 1'b0;
      ref_tick <= 1'b0;
      subsys_clk_en <= 1'b0;
      init_done <= 1'b0;
    end else begin
      core_tick <= core_pulse & ctrl_r[cpllc_pkg::CTRL_RUN_BIT];
      ref_tick <= ref_pulse_r & gen_run;
      subsys_clk_en <= gen_run;
      init_done <= gen_run;
    end
  end

  // Read data and address decode
  // Unaligned and unmapped addresses read zero and answer with an error
  always_comb begin
    rdata = '0;
    hit = 1'b1;
    if (paddr == cpllc_pkg::OFS_CTRL) begin
      rdata[1:0] = ctrl_r;
    end else if (paddr == cpllc_pkg::OFS_STATUS) begin
      rdata[cpllc_pkg::ST_DONE_BIT] = gen_run;
      rdata[cpllc_pkg::ST_BADSTRAP_BIT] = (strap_r > cpllc_pkg::STRAP_DIV8);
      rdata[cpllc_pkg::ST_SEL_LSB +: 2] = sel_r;
      rdata[cpllc_pkg::ST_STRAP_LSB +: 3] = strap_r;
      rdata[cpllc_pkg::ST_DIV_LSB +: 4] = decode_div(strap_r);
    end else if (paddr == cpllc_pkg::OFS_PERIOD) begin
      rdata[PER_W-1:0] = period_r;
    end else begin
      hit = 1'b0;
    end
  end

  // APB answer: one wait-free access cycle, flags set up in the setup cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      // Writes during the init wait are refused with an error
      pslverr <= ~hit | (pwrite & ~gen_run);
      prdata <= pwrite ? 32'h0 : rdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Control register write at the completing access edge
  // Only the low two bits exist; the upper write bits are dropped
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= cpllc_pkg::CTRL_RESET;
    end else if (psel && penable && pready && pwrite && !pslverr && paddr == cpllc_pkg::OFS_CTRL) begin
      ctrl_r <= pwdata[1:0];
    end
  end
endmodule // cpllc_core
`default_nettype wire

/* File: tb/cpllc_xtal_model.sv */
// Free-running crystal source feeding the clock generator
`timescale 1ns/1ns
`default_nettype none
module cpllc_xtal_model #(
  parameter int HALF_NS = 310
) (
  // Oscillator run control from the bench
  input wire logic xtal_en,
  // Oscillator output
  output logic xtal_in
);
  // One crystal serves all five core rates; only the sample rate it stands for changes
  // Runs from time zero so the init wait can finish
  // 62 core cycles a period keeps the pulse-rate core under its ceiling
  initial begin
    xtal_in = 1'b0;
    forever #(HALF_NS) xtal_in = xtal_en ? ~xtal_in : 1'b0;
  end
endmodule // cpllc_xtal_model
`default_nettype wire

/* File: tb/cpllc_core_assertions.sv */
// Port checker for the core clock generator
`timescale 1ns/1ns
`default_nettype none
module cpllc_core_chk (
  // Clock, reset, straps
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clkoutput_sel_bit0,
  input wire logic clkoutput_sel_bit1,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Generated
  input wire logic system_clock_output,
  input wire logic core_tick,
  input wire logic ref_tick,
  input wire logic subsys_clk_en,
  input wire logic init_done
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_blocked; !init_done |-> !subsys_clk_en && !core_tick && !ref_tick; endproperty
  a_blocked: assert property (p_blocked) else $error("clock leaked during init");
  property p_en_done; subsys_clk_en == init_done; endproperty
  a_en_done: assert property (p_en_done) else $error("enable and done disagree");
  property p_done_hold; init_done |=> init_done; endproperty
  a_done_hold: assert property (p_done_hold) else $error("init done dropped");
  property p_out_off; !clkoutput_sel_bit1 && !clkoutput_sel_bit0 |-> !system_clock_output; endproperty
  a_out_off: assert property (p_out_off) else $error("clock output not off");
  property p_zero_wait; psel && !penable |=> pready; endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("no ready in access");
  property p_wr_refused; pready && pwrite && !init_done |-> pslverr; endproperty
  a_wr_refused: assert property (p_wr_refused) else $error("early write taken");
  property p_ref_gap; ref_tick |=> !ref_tick [*8]; endproperty
  a_ref_gap: assert property (p_ref_gap) else $error("reference too fast");
  property p_unmapped; pready && paddr > 12'h008 |-> pslverr && prdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  c_init: cover property ($rose(init_done));
  c_err: cover property (pready && pslverr);
  c_tick: cover property (core_tick);
endmodule // cpllc_core_chk
bind cpllc_core cpllc_core_chk i_chk (.core_clk, .nrst, .clkoutput_sel_bit0, .clkoutput_sel_bit1, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .system_clock_output, .core_tick, .ref_tick,
  .subsys_clk_en, .init_done);
`default_nettype wire

/* File: tb/core_pll_and_clock_out_ctrl_bench.sv */
// Self-checking bench for the core clock generator
`timescale 1ns/1ns
`default_nettype none
module core_pll_and_clock_out_ctrl_bench;
  logic core_clk, nrst, xtal_in, xtal_en, psel, penable, pwrite, pready, pslverr, e;
  logic divider_strap_bit0, divider_strap_bit1, divider_strap_bit2, clkoutput_sel_bit0, clkoutput_sel_bit1;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, w;
  logic system_clock_output, core_tick, ref_tick, subsys_clk_en, init_done, prev;
  int mismatches, n_checks, s, d, m, c, k, ct, tg, te, seed;
  int div_tab[6] = '{1, 2, 4, 6, 8, 1};
  cpllc_xtal_model i_xtal (.xtal_en, .xtal_in);
  cpllc_core #(.INIT_CYCLES(8)) i_dut (.core_clk, .nrst, .xtal_in, .divider_strap_bit0, .divider_strap_bit1,
    .divider_strap_bit2, .clkoutput_sel_bit0, .clkoutput_sel_bit1, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .system_clock_output, .core_tick, .ref_tick, .subsys_clk_en, .init_done);
  // 100 MHz clock
  always #5 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until ready is sampled
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dt);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= dt; penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    // No cycle limit here; only the watchdog ends a hang
    while (pready !== 1'b1) @(posedge core_clk);
    q = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // Idle edge so the next call never rewrites these in the same step
    @(posedge core_clk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog sized well above the whole strap sweep
  initial begin
    repeat (60000) @(posedge core_clk);
    mismatches++;
    tally_and_finish;
  end
  initial begin
    core_clk = 1'b0; nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
    seed = 32'hf42a0657;
    xtal_en = 1'b1;
    for (s = 0; s < 6; s++) begin
      d = div_tab[s]; m = s % 4;
      // Straps move only while reset is held
      nrst <= 1'b0; divider_strap_bit0 <= s[0]; divider_strap_bit1 <= s[1]; divider_strap_bit2 <= s[2];
      clkoutput_sel_bit0 <= m[0]; clkoutput_sel_bit1 <= m[1];
      repeat (5) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      apb(1'b1, cpllc_pkg::OFS_CTRL, 32'h0);
      chk(e, 1);
      c = 4;
      while (init_done !== 1'b1 && c < 9000) begin c++; @(posedge core_clk); end
      chk(c >= (8 * d - 1) * 62 && c <= 8 * d * 62 + 10, 1);
      w = $random(seed);
      apb(1'b1, cpllc_pkg::OFS_STATUS, w);
      chk(e, 0);
      apb(1'b0, cpllc_pkg::OFS_STATUS, 32'h0);
      chk(q, (d << 12) | (s << 8) | (m << 4) | ((s > 4) << 1) | 1);
      apb(1'b0, cpllc_pkg::OFS_PERIOD, 32'h0);
      chk(q, 62 * d);
      apb(1'b0, 12'h00c + 12'(({$random(seed)} % 1020) * 4), w);
      chk(e, 1);
      chk(q, 0);
      // Count over four reference periods
      c = 0;
      while (ref_tick !== 1'b1 && c < 2000) begin c++; @(posedge core_clk); end
      k = 0; ct = 0; tg = 0; c = 0; prev = system_clock_output;
      while (k < 4 && c < 3000) begin
        @(posedge core_clk);
        c++;
        k += (ref_tick === 1'b1);
        ct += (core_tick === 1'b1);
        tg += (system_clock_output !== prev);
        prev = system_clock_output;
      end
      chk(c, 248 * d);
      chk(ct >= 223 && ct <= 225, 1);
      te = (m == 0) ? 0 : (m == 1) ? 8 * d : (m == 2) ? 32 : 64;
      chk(tg >= te - 1 && tg <= te + 1, 1);
      // Software gating of core pulses and of the clock output pin
      apb(1'b0, cpllc_pkg::OFS_CTRL, 32'h0);
      chk(q, 32'(cpllc_pkg::CTRL_RESET));
      apb(1'b1, cpllc_pkg::OFS_CTRL, w & 32'hffff_fffc);
      chk(e, 0);
      apb(1'b0, cpllc_pkg::OFS_CTRL, 32'h0);
      chk(q, 0);
      ct = 0; tg = 0;
      repeat (100) begin
        @(posedge core_clk);
        ct += (core_tick !== 1'b0);
        tg += (system_clock_output !== 1'b0);
      end
      chk(ct, 0);
      chk(tg, 0);
    end
    // Crystal loss: the reference stops, so the system resets the device
    xtal_en <= 1'b0;
    repeat (10) @(posedge core_clk);
    k = 0;
    repeat (200) begin
      @(posedge core_clk);
      k += (ref_tick !== 1'b0);
    end
    chk(k, 0);
    nrst <= 1'b0; xtal_en <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk(init_done, 0);
    nrst <= 1'b1;
    c = 0;
    while (init_done !== 1'b1 && c < 9000) begin c++; @(posedge core_clk); end
    chk(c < 9000, 1);
    tally_and_finish;
  end
endmodule // core_pll_and_clock_out_ctrl_bench
`default_nettype wire
